/* File: tt_touch_toggle.v */
/*
 * Digital core of a single-key capacitive toggle sensor: burst scheduling,
 * power-up polarity sensing and calibration, threshold detection with
 * hysteresis, detect integration, asymmetric drift compensation, and a
 * recalibration after a long continuous detection.
 * Assumes a charge-transfer front end on the same clock that answers each
 * burst request with one count strobe, and a pull resistor on the output
 * pin that selects the polarity at power-up.
 */
`timescale 1ns/1ps
`default_nettype none

`include "tt_consts.vh"

// Functional notes
// - Output changes only after four successive detecting acquisitions.
// - Low power schedule idles about 80 ms after each burst, except during calibration or a pending touch.
// - While a touch is pending, bursts run back to back without sleep.
// - A confirmed touch inverts the on/off state, then sleeping resumes.
// - An unconfirmed touch returns to sleeping and leaves the output alone.
// - Detection when signal exceeds reference by at least fixed 10 counts.
// - Integrator counts detections and clears at once on any miss.
// - About 60 s of continuous detection forces recalibration without toggling.
// - Full calibration at every power-up; no other forced recalibration input.
// - Reference tracks signal in limited steps, frozen while sensing an object.
// - Threshold and hysteresis levels are taken relative to current reference.
// - Reference follows removal quickly and approach slowly.
// - Active-high drives high for on; active-low drives low for on.
// - Power-up samples output pin pull: ground gives active-high, supply active-low.
module tt_touch_toggle #(
	parameter        CW        = 16,
	parameter [15:0] THRESH    = `TT_THRESH,
	parameter [15:0] HYST      = `TT_THRESH / 4,
	parameter [7:0]  N_UP      = `TT_DRIFT_UP_N,
	parameter [7:0]  N_DN      = `TT_DRIFT_DN_N,
	parameter [31:0] SLEEP_CYC = `TT_SLEEP_MS * `TT_CLK_MHZ * 1000,
	parameter [39:0] RECAL_CYC = `TT_RECAL_S * `TT_CLK_HZ,
	parameter [31:0] SENSE_CYC = (`TT_SENSE_NS * `TT_CLK_MHZ + 999) / 1000
) (
	// Clock and reset.
	input  wire          I_CLK_SYS,
	input  wire          I_RSTN,
	// Charge-transfer front end.
	output reg           O_BURST_REQ,
	input  wire          I_ACQ_VALID,
	input  wire [CW-1:0] I_ACQ_COUNT,
	// Output pin, three signals of a two-way pin.
	input  wire          I_OUT_PIN,
	output reg           O_OUT,
	output reg           O_OUT_OE_N,
	// Status.
	output reg           O_CAL_BUSY
);

	// One-hot schedule states.
	localparam [3:0] ST_SENSE = 4'h1;
	localparam [3:0] ST_SLEEP = 4'h2;
	localparam [3:0] ST_REQ   = 4'h4;
	localparam [3:0] ST_WAIT  = 4'h8;

	// Worked out as integers first, then cut to the 3-bit counters on purpose.
	localparam integer DI_LAST_I  = `TT_DI_TERM - 1;
	localparam integer CAL_LAST_I = (1 << `TT_CAL_SHIFT) - 1;
	localparam [2:0]   DI_LAST    = DI_LAST_I[2:0];
	localparam [2:0]   CAL_LAST   = CAL_LAST_I[2:0];

	reg           rst_s1_reg;
	reg           rst_n_reg;
	reg           pin_s1_reg;
	reg           pin_s2_reg;

	reg  [3:0]    state_reg,   state_next;
	reg  [31:0]   timer_reg,   timer_next;
	reg  [39:0]   hold_reg,    hold_next;
	reg  [CW-1:0] ref_reg,     ref_next;
	reg  [CW+2:0] sum_reg,     sum_next;
	reg  [2:0]    cal_cnt_reg, cal_cnt_next;
	reg           cal_reg,     cal_next;
	reg  [2:0]    integ_reg,   integ_next;
	reg           det_reg,     det_next;
	reg           on_reg,      on_next;
	reg           pol_low_reg, pol_low_next;
	reg  [7:0]    up_cnt_reg,  up_cnt_next;
	reg  [7:0]    dn_cnt_reg,  dn_cnt_next;
	reg           oe_n_next;
	reg           req_next;

	wire [CW:0]   sig_ext;
	wire [CW:0]   ref_ext;
	wire [CW:0]   hit_level;
	wire [CW:0]   rel_level;
	wire          hit;
	wire          still;
	wire [CW+2:0] sum_add;

	// Reset is released through two flops so every flop leaves reset together.
	always @(posedge I_CLK_SYS or negedge I_RSTN)
	begin
		if (!I_RSTN)
		begin
			rst_s1_reg <= 1'b0;
			rst_n_reg  <= 1'b0;
		end
		else
		begin
			rst_s1_reg <= 1'b1;
			rst_n_reg  <= rst_s1_reg;
		end
	end

	// The pin is outside the clock's domain; only the second flop is read.
	always @(posedge I_CLK_SYS or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
		begin
			pin_s1_reg <= 1'b0;
			pin_s2_reg <= 1'b0;
		end
		else
		begin
			pin_s1_reg <= I_OUT_PIN;
			pin_s2_reg <= pin_s1_reg;
		end
	end

	// Levels move with the reference, so drift never shifts sensitivity.
	assign sig_ext   = {1'b0, I_ACQ_COUNT};
	assign ref_ext   = {1'b0, ref_reg};
	// Counts wider than 16 bits would need wider threshold parameters.
	assign hit_level = ref_ext + {1'b0, THRESH[CW-1:0]};
	assign rel_level = ref_ext + {1'b0, THRESH[CW-1:0]} - {1'b0, HYST[CW-1:0]};
	assign hit       = (sig_ext >= hit_level);
	assign still     = (sig_ext >= rel_level);
	assign sum_add   = sum_reg + {3'h0, I_ACQ_COUNT};

	// Schedule, calibration, detection and drift in one next-state process.
	always @*
	begin
		state_next   = state_reg;
		timer_next   = timer_reg;
		hold_next    = hold_reg;
		ref_next     = ref_reg;
		sum_next     = sum_reg;
		cal_cnt_next = cal_cnt_reg;
		cal_next     = cal_reg;
		integ_next   = integ_reg;
		det_next     = det_reg;
		on_next      = on_reg;
		pol_low_next = pol_low_reg;
		up_cnt_next  = up_cnt_reg;
		dn_cnt_next  = dn_cnt_reg;
		oe_n_next    = O_OUT_OE_N;
		req_next     = 1'b0;

		// The detection timer runs only while an object is held on the key.
		if (det_reg)
			hold_next = hold_reg + 40'h1;

		case (state_reg)
			ST_SENSE:
			begin
				// Pin is released so the external pull alone sets its level.
				timer_next = timer_reg + 32'h1;
				if (timer_reg == SENSE_CYC - 32'h1)
				begin
					pol_low_next = pin_s2_reg;
					oe_n_next    = 1'b0;
					cal_next     = 1'b1;
					cal_cnt_next = 3'h0;
					sum_next     = {(CW+3){1'b0}};
					timer_next   = 32'h0;
					state_next   = ST_REQ;
				end
			end
			ST_SLEEP:
			begin
				timer_next = timer_reg + 32'h1;
				if (timer_reg == SLEEP_CYC - 32'h1)
				begin
					timer_next = 32'h0;
					state_next = ST_REQ;
				end
			end
			ST_REQ:
			begin
				req_next   = 1'b1;
				state_next = ST_WAIT;
			end
			ST_WAIT:
			begin
				if (I_ACQ_VALID && cal_reg)
				begin
					// Average a few bursts so one noisy burst cannot skew the baseline.
					sum_next     = sum_add;
					cal_cnt_next = cal_cnt_reg + 3'h1;
					state_next   = ST_REQ;
					if (cal_cnt_reg == CAL_LAST)
					begin
						ref_next   = sum_add[CW+`TT_CAL_SHIFT-1:`TT_CAL_SHIFT];
						cal_next   = 1'b0;
						state_next = ST_SLEEP;
					end
				end
				else if (I_ACQ_VALID && det_reg)
				begin
					// Reference frozen while the object is sensed.
					if (!still)
					begin
						det_next  = 1'b0;
						hold_next = 40'h0;
					end
					state_next = ST_SLEEP;
				end
				else if (I_ACQ_VALID && hit)
				begin
					up_cnt_next = 8'h0;
					dn_cnt_next = 8'h0;
					if (integ_reg == DI_LAST)
					begin
						on_next    = ~on_reg;
						det_next   = 1'b1;
						hold_next  = 40'h0;
						integ_next = 3'h0;
						state_next = ST_SLEEP;
					end
					else
					begin
						integ_next = integ_reg + 3'h1;
						state_next = ST_REQ;
					end
				end
				else if (I_ACQ_VALID)
				begin
					// A miss drops a pending touch; the output is untouched.
					integ_next = 3'h0;
					state_next = ST_SLEEP;
					if (I_ACQ_COUNT > ref_reg)
					begin
						dn_cnt_next = 8'h0;
						up_cnt_next = up_cnt_reg + 8'h1;
						if (up_cnt_reg >= N_UP - 8'h1)
						begin
							up_cnt_next = 8'h0;
							ref_next    = ref_reg + 1'b1;
						end
					end
					else if (I_ACQ_COUNT < ref_reg)
					begin
						up_cnt_next = 8'h0;
						dn_cnt_next = dn_cnt_reg + 8'h1;
						if (dn_cnt_reg >= N_DN - 8'h1)
						begin
							dn_cnt_next = 8'h0;
							ref_next    = ref_reg - 1'b1;
						end
					end
					else
					begin
						up_cnt_next = 8'h0;
						dn_cnt_next = 8'h0;
					end
				end
			end
			default:
			begin
				state_next = ST_SENSE;
				timer_next = 32'h0;
			end
		endcase

		// A stuck detection recalibrates; on_reg is kept, so the output holds.
		if (det_reg && (hold_reg == RECAL_CYC - 40'h1))
		begin
			det_next     = 1'b0;
			hold_next    = 40'h0;
			integ_next   = 3'h0;
			up_cnt_next  = 8'h0;
			dn_cnt_next  = 8'h0;
			cal_next     = 1'b1;
			cal_cnt_next = 3'h0;
			sum_next     = {(CW+3){1'b0}};
			timer_next   = 32'h0;
			req_next     = 1'b0;
			state_next   = ST_REQ;
		end
	end

	// State flops; the output is on from power-up only after a touch.
	always @(posedge I_CLK_SYS or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
		begin
			state_reg   <= ST_SENSE;
			timer_reg   <= 32'h0;
			hold_reg    <= 40'h0;
			ref_reg     <= {CW{1'b0}};
			sum_reg     <= {(CW+3){1'b0}};
			cal_cnt_reg <= 3'h0;
			cal_reg     <= 1'b1;
			integ_reg   <= 3'h0;
			det_reg     <= 1'b0;
			on_reg      <= `TT_RST_ON;
			pol_low_reg <= 1'b0;
			up_cnt_reg  <= 8'h0;
			dn_cnt_reg  <= 8'h0;
			O_OUT_OE_N  <= `TT_RST_OE_N;
			O_OUT       <= `TT_RST_OUT;
			O_BURST_REQ <= 1'b0;
			O_CAL_BUSY  <= 1'b1;
		end
		else
		begin
			state_reg   <= state_next;
			timer_reg   <= timer_next;
			hold_reg    <= hold_next;
			ref_reg     <= ref_next;
			sum_reg     <= sum_next;
			cal_cnt_reg <= cal_cnt_next;
			cal_reg     <= cal_next;
			integ_reg   <= integ_next;
			det_reg     <= det_next;
			on_reg      <= on_next;
			pol_low_reg <= pol_low_next;
			up_cnt_reg  <= up_cnt_next;
			dn_cnt_reg  <= dn_cnt_next;
			O_OUT_OE_N  <= oe_n_next;
			// Pin level is the on state flipped for active-low.
			O_OUT       <= oe_n_next ? 1'b0 : (on_next ^ pol_low_next);
			O_BURST_REQ <= req_next;
			O_CAL_BUSY  <= cal_next;
		end
	end

endmodule // tt_touch_toggle

`default_nettype wire

/* File: tt_consts.vh */
/*
 * Constants for the touch toggle detector: clock rate, schedule times,
 * detection figures, drift rates and reset values.
 * Assumes it is included by bare name into the detector's design file.
 */
`ifndef TT_CONSTS_VH
`define TT_CONSTS_VH

// System clock rate in MHz and in Hz (wide for long products).
`define TT_CLK_MHZ        100
`define TT_CLK_HZ         40'd100000000

// Sleep between bursts in the low power schedule, in ms.
`define TT_SLEEP_MS       80
// Continuous detection time that forces a recalibration, in s.
`define TT_RECAL_S        40'd60
// Settle time for the polarity resistor before the pin is sampled, in ns.
`define TT_SENSE_NS       1000

// Detection threshold in counts, fixed.
`define TT_THRESH         10
// Terminal count of the detect integrator.
`define TT_DI_TERM        4
// Calibration averages 2**TT_CAL_SHIFT bursts.
`define TT_CAL_SHIFT      2
// Idle acquisitions per one-count reference step, per direction.
`define TT_DRIFT_UP_N     20
`define TT_DRIFT_DN_N     2

// Reset values.
`define TT_RST_ON         1'b0
`define TT_RST_OE_N       1'b1
`define TT_RST_OUT        1'b0

`endif

/* File: tt_checker_assertions.sv */
/* Port checker for the toggle core.
   Assumes one clock and a sleep of SLEEP_CYC cycles between idle bursts. */
`timescale 1ns/1ps
`default_nettype none
module tt_checker #(
	parameter CW        = 16,
	parameter SLEEP_CYC = 20
) (
	// Core ports, watched only.
	input wire logic          I_CLK_SYS,
	input wire logic          I_RSTN,
	input wire logic          O_BURST_REQ,
	input wire logic          I_ACQ_VALID,
	input wire logic [CW-1:0] I_ACQ_COUNT,
	input wire logic          I_OUT_PIN,
	input wire logic          O_OUT,
	input wire logic          O_OUT_OE_N,
	input wire logic          O_CAL_BUSY
);
	logic [31:0] since_reg;
	logic        seen_reg;
	logic [3:0]  cal_reg;
	// Cycles since the last result, and results taken while calibrating.
	always_ff @(posedge I_CLK_SYS or negedge I_RSTN)
	begin
		if (!I_RSTN)
		begin
			since_reg <= 32'h0;
			seen_reg  <= 1'b0;
			cal_reg   <= 4'h0;
		end
		else
		begin
			since_reg <= I_ACQ_VALID ? 32'h0 : since_reg + 32'h1;
			seen_reg  <= seen_reg | I_ACQ_VALID;
			cal_reg   <= O_CAL_BUSY ? cal_reg + {3'h0, I_ACQ_VALID} : 4'h0;
		end
	end
	default clocking cb @(posedge I_CLK_SYS); endclocking
	default disable iff (!I_RSTN);
	// A toggle is an output change while the pin was already driven.
	sequence s_tog; $changed(O_OUT) && !O_OUT_OE_N && $past(!O_OUT_OE_N); endsequence
	property p_req_pulse; O_BURST_REQ |=> !O_BURST_REQ; endproperty
	a_req_pulse: assert property (p_req_pulse) else $error("request too wide");
	property p_req_gap;
		O_BURST_REQ && seen_reg && !O_CAL_BUSY |-> since_reg <= 32'h3 || since_reg >= SLEEP_CYC;
	endproperty
	a_req_gap: assert property (p_req_gap) else $error("bad burst spacing");
	property p_tog_cause; s_tog |-> $past(I_ACQ_VALID) || $past(I_ACQ_VALID, 2); endproperty
	a_tog_cause: assert property (p_tog_cause) else $error("toggle without result");
	property p_tog_sleep; s_tog |-> !O_BURST_REQ [*8]; endproperty
	a_tog_sleep: assert property (p_tog_sleep) else $error("no sleep after toggle");
	property p_cal_hold;
		O_CAL_BUSY && $past(O_CAL_BUSY) && !O_OUT_OE_N && $past(!O_OUT_OE_N) |-> $stable(O_OUT);
	endproperty
	a_cal_hold: assert property (p_cal_hold) else $error("output moved in calibration");
	property p_polarity; $fell(O_OUT_OE_N) |-> O_CAL_BUSY && O_OUT == $past(I_OUT_PIN); endproperty
	a_polarity: assert property (p_polarity) else $error("wrong off level");
	property p_oe_keep; !O_OUT_OE_N |=> !O_OUT_OE_N; endproperty
	a_oe_keep: assert property (p_oe_keep) else $error("pin released");
	property p_req_driven; O_BURST_REQ |-> !O_OUT_OE_N; endproperty
	a_req_driven: assert property (p_req_driven) else $error("burst before sense");
	property p_cal_len; $fell(O_CAL_BUSY) |-> cal_reg == 4'h4; endproperty
	a_cal_len: assert property (p_cal_len) else $error("calibration length");
	// Main scenarios reached.
	c_tog: cover property (s_tog);
	c_recal: cover property ($rose(O_CAL_BUSY));
	c_drive: cover property ($fell(O_OUT_OE_N));
endmodule // tt_checker
bind tt_touch_toggle tt_checker #(.CW(CW), .SLEEP_CYC(SLEEP_CYC)) u_chk (
	.I_CLK_SYS(I_CLK_SYS), .I_RSTN(I_RSTN), .O_BURST_REQ(O_BURST_REQ),
	.I_ACQ_VALID(I_ACQ_VALID), .I_ACQ_COUNT(I_ACQ_COUNT), .I_OUT_PIN(I_OUT_PIN),
	.O_OUT(O_OUT), .O_OUT_OE_N(O_OUT_OE_N), .O_CAL_BUSY(O_CAL_BUSY));
`default_nettype wire

/* File: tt_front_model.sv */
/* Front-end model: one result per burst request after i_dly cycles.
   Assumes a one-cycle request pulse on the same clock. */
`timescale 1ns/1ps
`default_nettype none
module tt_front_model (
	input  wire logic        i_clk,
	input  wire logic        i_req,
	input  wire logic [7:0]  i_dly,
	input  wire logic [15:0] i_level,
	output var  logic        o_valid,
	output var  logic [15:0] o_count
);
	logic [7:0] wait_reg = 8'h00;
	initial o_valid = 1'b0;
	initial o_count = 16'h0000;
	// Outside the strobe the count flips, so stale data never looks valid.
	always @(posedge i_clk)
	begin
		wait_reg <= i_req ? i_dly : wait_reg - {7'h00, wait_reg != 8'h00};
		o_valid  <= !i_req && wait_reg == 8'h01;
		o_count  <= (wait_reg == 8'h01) ? i_level : ~o_count;
	end
endmodule // tt_front_model
`default_nettype wire

/* File: tt_testbench.sv */
/* Bench for the toggle core with the front-end model.
   Assumes short sleep, recalibration and sense counts. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
	localparam int SLP = 20;
	logic        clk      = 1'b0;
	logic        rstn     = 1'b0;
	logic        pull     = 1'b0;
	logic        cal_seen = 1'b0;
	logic [7:0]  dly      = 8'h01;
	logic [15:0] lvl      = 16'h0064;
	logic        req, vld, out, oe_n, busy, pin;
	logic [15:0] cnt;
	int          failures = 0;
	int          checks   = 0;
	int          gap;
	always #5 clk = ~clk;
	// The pin shows the core's drive, else the polarity resistor.
	assign pin = oe_n ? pull : out;
	tt_touch_toggle #(.SLEEP_CYC(SLP), .RECAL_CYC(500), .SENSE_CYC(4)) uut (
		.I_CLK_SYS(clk), .I_RSTN(rstn), .O_BURST_REQ(req), .I_ACQ_VALID(vld),
		.I_ACQ_COUNT(cnt), .I_OUT_PIN(pin), .O_OUT(out), .O_OUT_OE_N(oe_n),
		.O_CAL_BUSY(busy));
	tt_front_model fe (.i_clk(clk), .i_req(req), .i_dly(dly), .i_level(lvl),
		.o_valid(vld), .o_count(cnt));
	task automatic print_verdict;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		checks++;
		if (got !== exp)
		begin
			failures++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk_gap(input int lo, input int hi);
		checks++;
		if (gap < lo || gap > hi)
		begin
			failures++;
			$display("[ERR] %0t gap %h exp %h to %h", $time, gap, lo, hi);
		end
	endtask
	// Bounded wait on falling edges for req (0), vld (1) or busy (2).
	// Running out ends the run; a selector avoids passing ports by reference.
	task automatic waitfor(input int sel, input logic v, output int n);
		logic s;
		n = 0;
		s = (sel == 0) ? req : ((sel == 1) ? vld : busy);
		while (s !== v && n < 3000)
		begin
			@(negedge clk);
			n++;
			s = (sel == 0) ? req : ((sel == 1) ? vld : busy);
		end
		if (n >= 3000)
		begin
			failures++;
			print_verdict;
		end
	endtask
	// One result at level v, then the wait until the next request.
	task automatic acq(input logic [15:0] v);
		int n;
		lvl = v;
		waitfor(1, 1'b1, n);
		@(negedge clk);
		waitfor(0, 1'b1, gap);
	endtask
	task automatic burst(input int n, input logic [15:0] v, input logic fast);
		repeat (n)
		begin
			acq(v);
			if (fast)
				chk_gap(1, 3);
			else
				chk_gap(SLP, SLP + 3);
		end
	endtask
	task automatic powerup(input logic p);
		int n;
		rstn = 1'b0;
		pull = p;
		dly = 8'h01;
		lvl = 16'h0064;
		repeat (4) @(negedge clk);
		rstn = 1'b1;
		chk_bit(oe_n, 1'b1);
		waitfor(2, 1'b0, n);
		chk_bit(oe_n, 1'b0);
		chk_bit(out, p);
		waitfor(0, 1'b1, n);
	endtask
	// A count one below the threshold never detects.
	task automatic scn_below;
		burst(1, 16'h006D, 1'b0);
		chk_bit(out, 1'b0);
	endtask
	// Three hits then a miss: the pending touch is dropped and the output kept.
	task automatic scn_denied;
		burst(3, 16'h006E, 1'b1);
		chk_bit(out, 1'b0);
		burst(1, 16'h0064, 1'b0);
		chk_bit(out, 1'b0);
	endtask
	// The miss cleared the integrator, so a full four hits are needed again.
	task automatic scn_confirm;
		burst(1, 16'h006E, 1'b1);
		chk_bit(out, 1'b0);
		burst(2, 16'h006E, 1'b1);
		burst(1, 16'h006E, 1'b0);
		chk_bit(out, 1'b1);
	endtask
	// Inside the hysteresis band the detection holds, so hits cannot toggle again.
	task automatic scn_hold;
		burst(1, 16'h006D, 1'b0);
		burst(4, 16'h006E, 1'b0);
		chk_bit(out, 1'b1);
		burst(1, 16'h006B, 1'b0);
		burst(3, 16'h006E, 1'b1);
		burst(1, 16'h006E, 1'b0);
		chk_bit(out, 1'b0);
	endtask
	// A detection held past the limit recalibrates without a toggle.
	task automatic scn_recal;
		repeat (40)
		begin
			acq(16'h006E);
			cal_seen = cal_seen | busy;
		end
		chk_bit(cal_seen, 1'b1);
		chk_bit(out, 1'b0);
	endtask
	// Falling counts pull the reference down fast, so a smaller rise detects.
	task automatic scn_drift;
		dly = 8'h06;
		burst(8, 16'h0064, 1'b0);
		burst(3, 16'h0076, 1'b1);
		burst(1, 16'h0076, 1'b0);
		chk_bit(out, 1'b1);
	endtask
	// After a power cycle with the pin pulled high, a touch drives the pin low.
	task automatic scn_act_low;
		powerup(1'b1);
		burst(3, 16'h006E, 1'b1);
		burst(1, 16'h006E, 1'b0);
		chk_bit(out, 1'b0);
	endtask
	initial
	begin
		powerup(1'b0);
		scn_below;
		scn_denied;
		scn_confirm;
		scn_hold;
		scn_recal;
		scn_drift;
		scn_act_low;
		print_verdict;
	end
endmodule // testbench
`default_nettype wire
